// ==== core/irq_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

`define OUT_CTRL_ADDR     8'h08
`define SRC_ENABLE_ADDR   8'h09
`define SRC_STATUS_ADDR   8'h0A
`define CTRL_RESET        8'h00
`define ENABLE_RESET      8'h00
`define STATUS_RESET      8'h00
`define CTRL_MODE_BIT     7
`define CTRL_POL_BIT      2
`define CTRL_TYPE_BIT     1
`define CTRL_GLOBAL_BIT   0
`define CTRL_WRITE_MASK   8'h87
`define BIT_ERROR         7
`define BIT_LIFT          6
`define BIT_PORT0         2
`define BIT_SAMPLE        1
`define BIT_TOUCH         0
`define CLOCK_MHZ         20
`define PULSE_MIN_US      50
`define PULSE_MAX_US      150
`define PULSE_CYCLES      ((`PULSE_MIN_US * `CLOCK_MHZ + `PULSE_MAX_US * `CLOCK_MHZ) / 2)
`define PORT_RESP_NS      5000
`define PORT_RESP_CYCLES  (`PORT_RESP_NS * `CLOCK_MHZ / 1000)

`endif

// ==== core/irq_pkg.sv ====
// Types shared by the interrupt controller
package irq_pkg;

   typedef struct packed {
      logic       touch_calc_error;
      logic       touch_lift;
      logic [3:0] port_activity;
      logic       touch_sample_ready;
      logic       touch_detected;
   } irq_events_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      SAMPLE_TIMER,
      SAMPLE_HOST,
      SAMPLE_ACQ
   } acquisition_mode_t;

endpackage : irq_pkg

// ==== core/touch_port_irq_controller.sv ====
// Interrupt controller for touch and port events with a single pin
`timescale 1ns/1ps
`default_nettype none
`include "irq_map.svh"

module touch_port_irq_controller
   import irq_pkg::*;
#(
   parameter int PULSE_LEN = `PULSE_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire reg_req_t          req,
   output logic [7:0]             rdata,
   input  wire irq_events_t       events,
   input  wire logic              touch_invalid,
   input  wire logic              pen_down,
   input  wire logic              sample_data_read,
   input  wire acquisition_mode_t sample_mode,
   output logic                   irq_pin
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_r;
   logic [7:0]  enable_r;
   logic [7:0]  status_r;
   logic [7:0]  status_nxt;
   logic [7:0]  shadow;
   logic [7:0]  set_vec;
   logic [7:0]  clr_vec;
   logic        mode_chg;
   logic        rd_status;
   logic        rd_enable;
   logic        pen_mode;
   logic        level_act;
   logic        level_d_r;
   logic        pulse_act;
   logic [15:0] pulse_cnt_r;

   // Port event to pin limit, in clock cycles
   localparam int PORT_RESP = `PORT_RESP_CYCLES;

   assign pen_mode  = ~ctrl_r[`CTRL_MODE_BIT];
   assign rd_status = req.rd && req.addr == `SRC_STATUS_ADDR;
   assign rd_enable = req.rd && req.addr == `SRC_ENABLE_ADDR;
   assign mode_chg  = req.wr && req.addr == `OUT_CTRL_ADDR &&
                      req.wdata[`CTRL_MODE_BIT] != ctrl_r[`CTRL_MODE_BIT];
   // Status visible at the read is the shadow; only its bits are cleared
   assign shadow    = status_r;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `CTRL_RESET;
      end else if (req.wr && req.addr == `OUT_CTRL_ADDR) begin
         ctrl_r <= req.wdata & `CTRL_WRITE_MASK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable_r <= `ENABLE_RESET;
      end else if (req.wr && req.addr == `SRC_ENABLE_ADDR) begin
         enable_r <= req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Status capture
   // ----------------------------------------------------------------
   always_comb begin
      set_vec = events;
      set_vec[`BIT_ERROR] = events.touch_calc_error | touch_invalid;
      clr_vec = 8'h00;
      if (rd_status || rd_enable) begin
         clr_vec = shadow;
      end
      // Sample-ready waits for the data itself outside acquisition mode
      if (sample_mode != SAMPLE_ACQ) begin
         clr_vec[`BIT_SAMPLE] = 1'b0;
      end
      if (sample_data_read) begin
         clr_vec[`BIT_SAMPLE] = shadow[`BIT_SAMPLE];
      end
      if (pen_mode && pen_down) begin
         clr_vec[`BIT_TOUCH] = 1'b0;
      end
      status_nxt = (status_r & ~clr_vec) | set_vec;
      if (mode_chg) begin
         status_nxt = `STATUS_RESET;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= `STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_comb begin
      rdata = 8'h00;
      if (req.addr == `OUT_CTRL_ADDR) begin
         rdata = ctrl_r;
      end else if (req.addr == `SRC_ENABLE_ADDR) begin
         rdata = enable_r;
      end else if (req.addr == `SRC_STATUS_ADDR) begin
         rdata = shadow;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   always_comb begin
      if (pen_mode) begin
         // Status content is deliberately left out in pen-down mode
         level_act = (pen_down & enable_r[`BIT_TOUCH])
                   | (|(events & enable_r & 8'hFE));
      end else begin
         // Status bits masked by the enables decide the pin
         level_act = |(status_r & enable_r);
      end
      level_act = level_act & ctrl_r[`CTRL_GLOBAL_BIT] & ~mode_chg;
   end

   // Edge pulse: fires on the rise of the level, lasts PULSE_LEN cycles
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         level_d_r   <= 1'b0;
         pulse_cnt_r <= 16'h0000;
      end else begin
         level_d_r <= level_act;
         if (mode_chg || !ctrl_r[`CTRL_GLOBAL_BIT]) begin
            pulse_cnt_r <= 16'h0000;
         end else if (level_act && !level_d_r) begin
            pulse_cnt_r <= PULSE_LEN[15:0];
         end else if (pulse_cnt_r != 16'h0000) begin
            pulse_cnt_r <= pulse_cnt_r - 16'h0001;
         end
      end
   end
   // Gated here too: the counter only clears one edge after the cause
   assign pulse_act = (pulse_cnt_r != 16'h0000) &
                      ctrl_r[`CTRL_GLOBAL_BIT] & ~mode_chg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_pin <= 1'b1;
      end else if (pen_mode || !ctrl_r[`CTRL_TYPE_BIT]) begin
         irq_pin <= level_act ~^ ctrl_r[`CTRL_POL_BIT];
      end else begin
         irq_pin <= pulse_act ~^ ctrl_r[`CTRL_POL_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   pen_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && pen_down && enable_r[0] && ctrl_r[0] && !mode_chg)
      |=> irq_pin == $past(ctrl_r[2]))
      else $error("pin not asserted while pen down");

   normal_level_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!pen_mode && !ctrl_r[1] && ctrl_r[0] && |(status_r & enable_r) &&
       !mode_chg)
      |=> irq_pin == $past(ctrl_r[2]))
      else $error("normal level not asserted");

   mode_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode_chg |=> status_r == 8'h00)
      else $error("status not cleared on mode change");

   global_off_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!ctrl_r[0] && !$past(ctrl_r[0])) |-> irq_pin != ctrl_r[2])
      else $error("pin asserted with global off");

   event_sets_a: assert property (@(posedge clock) disable iff (!reset_n)
      (events.port_activity[0] && !mode_chg) |=> status_r[`BIT_PORT0])
      else $error("event did not set status");

   read_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      (rd_status && status_r[6] && !events.touch_lift && !mode_chg)
      |=> !status_r[6])
      else $error("read did not clear status");

   edge_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
      (level_act && !level_d_r && !pen_mode && ctrl_r[1] && ctrl_r[0])
      |=> pulse_cnt_r == PULSE_LEN[15:0])
      else $error("edge pulse not started");

   touch_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && pen_down && status_r[0] && !mode_chg) |=> status_r[0])
      else $error("touch bit cleared while pen down");

   touch_read_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && pen_down && rd_status && status_r[0] && !mode_chg)
      |=> status_r[0])
      else $error("read cleared touch bit while pen down");

   // ----------------------------------------------------------------
   // Pin checks
   // ----------------------------------------------------------------
   // Pin sense is judged against the polarity in force when it was set, except in port_latency_a
   pen_or_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && ctrl_r[0] && !mode_chg && |(events & enable_r & 8'hFE))
      |=> irq_pin == $past(ctrl_r[2]))
      else $error("enabled source not ORed in pen-down mode");

   pen_type_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && !level_act) |=> irq_pin != $past(ctrl_r[2]))
      else $error("pulse seen in pen-down mode");

   pen_status_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && !pen_down && !(|(events & enable_r & 8'hFE)))
      |=> irq_pin != $past(ctrl_r[2]))
      else $error("status drove pin in pen-down mode");

   pen_global_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pen_mode && pen_down && !ctrl_r[0]) |=> irq_pin != $past(ctrl_r[2]))
      else $error("pen asserted pin with global off");

   pol_sense_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!pen_mode && !ctrl_r[1] && level_act) |=> irq_pin == $past(ctrl_r[2]))
      else $error("pin sense does not follow polarity");

   normal_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!pen_mode && !ctrl_r[1] && !level_act)
      |=> irq_pin != $past(ctrl_r[2]))
      else $error("pin asserted with no enabled status");

   edge_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!pen_mode && ctrl_r[1] && !pulse_act) |=> irq_pin != $past(ctrl_r[2]))
      else $error("edge pin asserted outside pulse");

   edge_global_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!pen_mode && ctrl_r[1] && !ctrl_r[0]) |=> irq_pin != $past(ctrl_r[2]))
      else $error("edge pin asserted with global off");

   pulse_count_a: assert property (@(posedge clock) disable iff (!reset_n)
      (pulse_cnt_r != 16'h0000 && !mode_chg && ctrl_r[0] &&
       !(level_act && !level_d_r))
      |=> pulse_cnt_r == $past(pulse_cnt_r) - 16'h0001)
      else $error("edge pulse length wrong");

   global_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
      !ctrl_r[0] |=> pulse_cnt_r == 16'h0000)
      else $error("pulse running with global off");

   mode_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode_chg |=> pulse_cnt_r == 16'h0000)
      else $error("pulse survived mode change");

   mode_pin_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode_chg |=> irq_pin != $past(ctrl_r[2]))
      else $error("pending output survived mode change");

   // Level mode only: an edge pulse may already be running
   port_latency_a: assert property (@(posedge clock) disable iff (!reset_n)
      (events.port_activity[0] && enable_r[`BIT_PORT0] && !pen_mode &&
       !ctrl_r[1] && ctrl_r[0] && !mode_chg)
      |-> ##[1:PORT_RESP] irq_pin == ctrl_r[2])
      else $error("port event too slow to reach pin");

   // ----------------------------------------------------------------
   // Status checks
   // ----------------------------------------------------------------
   write_ignore_a: assert property (@(posedge clock) disable iff (!reset_n)
      (req.wr && !req.rd && req.addr == `SRC_STATUS_ADDR &&
       !sample_data_read)
      |=> status_r == ($past(status_r) | $past(set_vec)))
      else $error("status write had an effect");

   shadow_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
      (rd_status && !mode_chg)
      |=> (status_r & $past(set_vec)) == $past(set_vec))
      else $error("event lost during status read");

   enable_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      (rd_enable && sample_mode == SAMPLE_ACQ && !pen_mode &&
       set_vec == 8'h00 && !mode_chg)
      |=> status_r == 8'h00)
      else $error("enable read did not clear status");

   error_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      (touch_invalid && !mode_chg) |=> status_r[`BIT_ERROR])
      else $error("invalid touch did not set error");

   lane_order_a: assert property (@(posedge clock) disable iff (!reset_n)
      (events.touch_lift && !mode_chg) |=> status_r[`BIT_LIFT])
      else $error("lift event in wrong bit");

   port3_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      (events.port_activity[3] && !mode_chg) |=> status_r[5])
      else $error("port three event in wrong bit");

   touch_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      (events.touch_detected && !enable_r[0] && !mode_chg)
      |=> status_r[`BIT_TOUCH])
      else $error("disabled source not recorded");

   sample_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
      (sample_mode != SAMPLE_ACQ && !sample_data_read && status_r[1] &&
       !mode_chg)
      |=> status_r[1])
      else $error("sample-ready cleared before data read");

   sample_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      (sample_data_read && !events.touch_sample_ready && !mode_chg)
      |=> !status_r[`BIT_SAMPLE])
      else $error("data read did not clear sample-ready");

   sticky_a: assert property (@(posedge clock) disable iff (!reset_n)
      (!rd_status && !rd_enable && !sample_data_read && !mode_chg)
      |=> (status_r & $past(status_r)) == $past(status_r))
      else $error("status bit dropped without a clear");

endmodule : touch_port_irq_controller

`default_nettype wire

// ==== bench/host_model.sv ====
// Host processor model driving register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model
   import irq_pkg::*;
(
   input  wire logic       clock,
   output var  reg_req_t   req,
   input  wire logic [7:0] rdata
);
   initial req = '0;
   // Request held up to the edge that takes it; data taken at that edge
   task automatic access(input logic w, input logic [7:0] a, d,
                         output logic [7:0] q);
      @(posedge clock);
      #1;
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clock);
      q = rdata;
      #1;
      req = '0;
   endtask : access
endmodule : host_model
`default_nettype wire

// ==== bench/touch_port_irq_controller_test.sv ====
// Self-checking bench for the touch and port interrupt controller
`timescale 1ns/1ps
`default_nettype none
module touch_port_irq_controller_test
   import irq_pkg::*;
;
   typedef struct packed {logic [7:0] ev; logic inv; logic [7:0] st;} row_t;
   logic              clock;
   logic              reset_n;
   reg_req_t          req;
   logic [7:0]        rdata;
   irq_events_t       events;
   logic              touch_invalid;
   logic              pen_down;
   logic              sample_data_read;
   acquisition_mode_t sample_mode;
   logic              irq_pin;
   logic [7:0]        q;
   int                bad_count;
   int                cmp_count;
   row_t              rows [9];

   host_model host (.clock(clock), .req(req), .rdata(rdata));
   touch_port_irq_controller #(.PULSE_LEN(4)) dut (
      .clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
      .events(events), .touch_invalid(touch_invalid), .pen_down(pen_down),
      .sample_data_read(sample_data_read), .sample_mode(sample_mode),
      .irq_pin(irq_pin));

   task automatic check(input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic [7:0] a, exp);
      host.access(1'b0, a, 8'h00, q);
      check(q, exp);
   endtask : rd
   task automatic wr(input logic [7:0] a, d);
      host.access(1'b1, a, d, q);
   endtask : wr
   task automatic pulse(input logic [7:0] ev, input logic inv);
      @(posedge clock);
      #1;
      events = ev;
      touch_invalid = inv;
      @(posedge clock);
      #1;
      events = '0;
      touch_invalid = 1'b0;
   endtask : pulse
   task automatic pin_is(input int n, input logic exp);
      repeat (n) @(posedge clock);
      #1;
      check({7'h00, irq_pin}, {7'h00, exp});
   endtask : pin_is
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Whole run is under 1000 cycles; allow four times that
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      events = '0;
      touch_invalid = 1'b0;
      pen_down = 1'b0;
      sample_data_read = 1'b0;
      sample_mode = SAMPLE_ACQ;
      bad_count = 0;
      cmp_count = 0;
      rows = '{'{8'h01, 1'b0, 8'h01}, '{8'h02, 1'b0, 8'h02},
               '{8'h04, 1'b0, 8'h04}, '{8'h08, 1'b0, 8'h08},
               '{8'h10, 1'b0, 8'h10}, '{8'h20, 1'b0, 8'h20},
               '{8'h40, 1'b0, 8'h40}, '{8'h80, 1'b0, 8'h80},
               '{8'h00, 1'b1, 8'h80}};
      repeat (20) @(posedge clock);
      #1;
      reset_n = 1'b1;
      pin_is(0, 1'b1);
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      rd(8'h0A, 8'h00);
      rd(8'h33, 8'h00);
      $display("test reset done");
      wr(8'h09, 8'hFF);
      wr(8'h08, 8'h85);
      foreach (rows[i]) begin
         pulse(rows[i].ev, rows[i].inv);
         pin_is(2, 1'b1);
         rd(8'h0A, rows[i].st);
         rd(8'h0A, 8'h00);
         pin_is(2, 1'b0);
      end
      $display("test table done");
      wr(8'h09, 8'h00);
      pulse(8'h10, 1'b0);
      pin_is(2, 1'b0);
      rd(8'h0A, 8'h10);
      wr(8'h09, 8'hFF);
      pulse(8'h08, 1'b0);
      fork
         rd(8'h0A, 8'h08);
         pulse(8'h04, 1'b0);
      join
      rd(8'h0A, 8'h04);
      pulse(8'h20, 1'b0);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'h20);
      pulse(8'h40, 1'b0);
      rd(8'h09, 8'hFF);
      rd(8'h0A, 8'h00);
      sample_mode = SAMPLE_HOST;
      pulse(8'h02, 1'b0);
      rd(8'h0A, 8'h02);
      rd(8'h0A, 8'h02);
      sample_data_read = 1'b1;
      @(posedge clock);
      #1;
      sample_data_read = 1'b0;
      rd(8'h0A, 8'h00);
      sample_mode = SAMPLE_TIMER;
      pulse(8'h02, 1'b0);
      rd(8'h0A, 8'h02);
      rd(8'h0A, 8'h02);
      sample_data_read = 1'b1;
      @(posedge clock);
      #1;
      sample_data_read = 1'b0;
      rd(8'h0A, 8'h00);
      $display("test status done");
      wr(8'h08, 8'h83);
      pulse(8'h08, 1'b0);
      pin_is(2, 1'b0);
      pin_is(6, 1'b1);
      rd(8'h0A, 8'h08);
      pulse(8'h20, 1'b0);
      wr(8'h08, 8'h05);
      rd(8'h0A, 8'h00);
      pin_is(1, 1'b0);
      $display("test edge done");
      pen_down = 1'b1;
      pulse(8'h01, 1'b0);
      pin_is(1, 1'b1);
      rd(8'h0A, 8'h01);
      rd(8'h0A, 8'h01);
      pin_is(0, 1'b1);
      wr(8'h08, 8'h07);
      pin_is(8, 1'b1);
      wr(8'h08, 8'h06);
      pin_is(2, 1'b0);
      wr(8'h08, 8'h05);
      pen_down = 1'b0;
      pin_is(3, 1'b0);
      pulse(8'h10, 1'b0);
      pin_is(3, 1'b0);
      host.access(1'b0, 8'h0A, 8'h00, q);
      check(q & 8'hFE, 8'h10);
      $display("test pen done");
      stop_test();
   end
endmodule : touch_port_irq_controller_test
`default_nettype wire
